// file: config1_regs.sv
// configuration register one pair: non-volatile image and volatile copy
`timescale 1ns/1ps
module config1_regs
  import config1_pkg::*;
#(
  parameter logic [7:0] NV_IMAGE_INIT = CONFIG1_NV_RESET,
  parameter int         SWITCH_CYC    = WIDTH_SWITCH_CYC
) (
  // clock and reset
  input  wire logic       I_REF_CLK,
  input  wire logic       I_NRST,
  input  wire logic       I_SW_RST,
  // decoded command from the serial front end
  input  wire logic       I_CMD_VALID,
  input  wire logic [7:0] I_CMD_OP,
  input  wire logic [1:0] I_CMD_BYTES,
  input  wire logic [7:0] I_CMD_DATA,
  input  wire logic       I_CMD_HITS_CONFIG1,
  input  wire logic       I_CMD_TO_VOLATILE,
  // device pins
  input  wire logic       I_CS_N,
  input  wire logic       I_WP_N,
  input  wire logic       I_LINE3,
  // state from neighbouring registers and the array engine
  input  wire logic [2:0] I_PROTECTION_MODE_FIELD,
  input  wire logic       I_STATUS_PROTECT_PIN_GATED,
  input  wire logic       I_FOUR_WIRE_COMMAND_PROTOCOL,
  input  wire logic       I_LINE3_RESET_ENABLE,
  input  wire logic       I_SUSPENDED,
  input  wire logic       I_BUSY,
  // region program and erase check
  input  wire logic       I_REGION_OP_VALID,
  input  wire logic [1:0] I_REGION_OP_INDEX,
  // read answer
  output logic            O_READ_VALID,
  output logic [7:0]      O_READ_DATA,
  // controls to the rest of the device
  output logic            O_WRITE_ENABLE_LATCH,
  output logic            O_WRITE_DONE,
  output logic            O_WRITE_REFUSED,
  output logic            O_MAP_INVERT,
  output logic [3:0]      O_REGION_LOCK_BITS,
  output logic            O_REGION_OP_REFUSED,
  output logic            O_FOUR_BIT_WIDTH,
  output logic            O_WP_EFFECTIVE_N,
  output logic            O_LINE3_IS_RESET,
  output logic            O_HW_RESET
);

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  logic [2:0] pin_raw;
  logic [2:0] pin_lvl;

  assign pin_raw = {I_LINE3, I_WP_N, I_CS_N};

  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_sync
      pin_sync3 #(
        .RESET_LEVEL (1'b1)
      ) u_sync (
        .i_clk   (I_REF_CLK),
        .i_nrst  (I_NRST),
        .i_pin   (pin_raw[g]),
        .o_level (pin_lvl[g])
      );
    end
  endgenerate

  logic cs_n_s;
  logic wp_n_s;
  logic line3_s;

  assign cs_n_s  = pin_lvl[0];
  assign wp_n_s  = pin_lvl[1];
  assign line3_s = pin_lvl[2];

  // ****************************************************************
  // register state
  // ****************************************************************
  logic [7:0] nv_r;
  logic       suspend_r;
  logic       map_invert_r;
  logic       wide_io_r;
  logic       reg_lock_r;
  logic       boot_load_r;
  logic       nv_wen_r;
  logic       v_wen_r;
  logic       hw_rst_r;
  logic       four_bit_r;
  logic [7:0] switch_cnt_r;

  // ****************************************************************
  // command decode
  // ****************************************************************
  logic is_wrr;
  logic is_write_any_register_cmd;
  logic wr_cmd;
  logic to_vol;
  logic protected_now;
  logic wen_ok;
  logic wr_ok;
  logic nv_wr;
  logic vol_wr;
  logic reload;

  assign is_wrr  = I_CMD_VALID && (I_CMD_OP == WRITE_REGISTERS_CMD)
                   && (I_CMD_BYTES >= WRR_CONFIG_BYTES);
  assign is_write_any_register_cmd = I_CMD_VALID && (I_CMD_OP == WRITE_ANY_REGISTER_CMD)
                   && I_CMD_HITS_CONFIG1;
  assign wr_cmd  = (is_wrr || is_write_any_register_cmd) && !I_BUSY;

  // write-registers lands in the volatile copy only after the volatile enable
  assign to_vol = is_write_any_register_cmd ? I_CMD_TO_VOLATILE : (v_wen_r && !nv_wen_r);

  // lock bit, lock default, or protect bit gated by the pin
  assign protected_now = reg_lock_r
                         || nv_r[REG_LOCK_BIT]
                         || (I_STATUS_PROTECT_PIN_GATED && !O_WP_EFFECTIVE_N);

  assign wen_ok = to_vol ? (v_wen_r || nv_wen_r) : nv_wen_r;
  assign wr_ok  = wr_cmd && wen_ok && !protected_now;
  assign nv_wr  = wr_ok && !to_vol;
  assign vol_wr = wr_ok && to_vol;

  // volatile reload from the image: after power-on, hardware or software reset
  assign reload = boot_load_r || hw_rst_r || I_SW_RST;

  // ****************************************************************
  // write enable latch
  // ****************************************************************
  always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      nv_wen_r <= 1'b0;
      v_wen_r  <= 1'b0;
    end else if (hw_rst_r || I_SW_RST) begin
      nv_wen_r <= 1'b0;
      v_wen_r  <= 1'b0;
    end else if (wr_ok) begin
      nv_wen_r <= 1'b0;
      v_wen_r  <= 1'b0;
    end else if (I_CMD_VALID && (I_CMD_OP == NONVOLATILE_WRITE_ENABLE_CMD)) begin
      nv_wen_r <= 1'b1;
    end else if (I_CMD_VALID && (I_CMD_OP == VOLATILE_WRITE_ENABLE_CMD)) begin
      v_wen_r  <= 1'b1;
    end
  end

  // ****************************************************************
  // non-volatile image
  // ****************************************************************
  always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      nv_r <= NV_IMAGE_INIT;
    end else if (nv_wr) begin
      nv_r[SUSPEND_BIT] <= nv_r[SUSPEND_BIT];
      nv_r[MAP_INVERT_BIT] <= I_CMD_DATA[MAP_INVERT_BIT];
      // one-time bits only go from 0 to 1
      nv_r[LOCK_HI_BIT:LOCK_LO_BIT] <= nv_r[LOCK_HI_BIT:LOCK_LO_BIT]
                                       | I_CMD_DATA[LOCK_HI_BIT:LOCK_LO_BIT];
      nv_r[WIDE_IO_BIT] <= I_CMD_DATA[WIDE_IO_BIT];
      if (I_PROTECTION_MODE_FIELD == PROT_MODE_OPEN) begin
        nv_r[REG_LOCK_BIT] <= nv_r[REG_LOCK_BIT] | I_CMD_DATA[REG_LOCK_BIT];
      end
    end
  end

  // ****************************************************************
  // volatile copy
  // ****************************************************************
  always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      boot_load_r <= 1'b1;
    end else begin
      boot_load_r <= 1'b0;
    end
  end

  always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      suspend_r <= CONFIG1_VOL_RESET[SUSPEND_BIT];
    end else if (reload) begin
      suspend_r <= nv_r[SUSPEND_BIT];
    end else begin
      suspend_r <= I_SUSPENDED;
    end
  end

  always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      map_invert_r <= CONFIG1_VOL_RESET[MAP_INVERT_BIT];
      wide_io_r    <= CONFIG1_VOL_RESET[WIDE_IO_BIT];
    end else if (reload) begin
      map_invert_r <= nv_r[MAP_INVERT_BIT];
      wide_io_r    <= nv_r[WIDE_IO_BIT];
    end else if (vol_wr) begin
      map_invert_r <= I_CMD_DATA[MAP_INVERT_BIT];
      wide_io_r    <= I_CMD_DATA[WIDE_IO_BIT];
    end
  end

  // software reset leaves the lock alone; it is set by a volatile write or loaded from the image at power-on or hardware reset
  always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      reg_lock_r <= CONFIG1_VOL_RESET[REG_LOCK_BIT];
    end else if (boot_load_r || hw_rst_r) begin
      reg_lock_r <= nv_r[REG_LOCK_BIT];
    end else if (vol_wr && I_CMD_DATA[REG_LOCK_BIT]) begin
      reg_lock_r <= 1'b1;
    end
  end

  // ****************************************************************
  // data width and pin roles
  // ****************************************************************
  logic four_bit_want;

  assign four_bit_want = wide_io_r || I_FOUR_WIRE_COMMAND_PROTOCOL;

  // width change settles after the switch delay
  always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      four_bit_r   <= 1'b0;
      switch_cnt_r <= 8'h00;
    end else if (four_bit_want == four_bit_r) begin
      switch_cnt_r <= 8'h00;
    end else if (switch_cnt_r >= 8'(SWITCH_CYC - 1)) begin
      four_bit_r   <= four_bit_want;
      switch_cnt_r <= 8'h00;
    end else begin
      switch_cnt_r <= switch_cnt_r + 8'h01;
    end
  end

  always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      O_FOUR_BIT_WIDTH <= 1'b0;
      O_WP_EFFECTIVE_N <= 1'b1;
      O_LINE3_IS_RESET <= 1'b0;
    end else begin
      O_FOUR_BIT_WIDTH <= four_bit_r;
      // protect pin is data line 2 in wide mode and reads inactive
      O_WP_EFFECTIVE_N <= four_bit_r ? 1'b1 : wp_n_s;
      // line 3 is reset while deselected or in narrow width, data only while selected in four bit width
      O_LINE3_IS_RESET <= I_LINE3_RESET_ENABLE && (cs_n_s || !four_bit_r);
    end
  end

  // hardware reset pulse taken from line 3 while it acts as reset
  always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      hw_rst_r   <= 1'b0;
      O_HW_RESET <= 1'b0;
    end else begin
      hw_rst_r   <= O_LINE3_IS_RESET && !line3_s && !hw_rst_r && !O_HW_RESET;
      O_HW_RESET <= hw_rst_r;
    end
  end

  // ****************************************************************
  // read path and status outputs
  // ****************************************************************
  logic [7:0] vol_view;
  logic       rd_vol;
  logic       rd_any;

  // lock copies come straight from the image so they track at once
  assign vol_view = {suspend_r, map_invert_r, nv_r[LOCK_HI_BIT:LOCK_LO_BIT],
                     wide_io_r, reg_lock_r};
  assign rd_vol   = I_CMD_VALID && (I_CMD_OP == READ_CONFIG_ONE_CMD);
  assign rd_any   = I_CMD_VALID && (I_CMD_OP == READ_ANY_REGISTER_CMD)
                    && I_CMD_HITS_CONFIG1;

  always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      O_READ_VALID <= 1'b0;
      O_READ_DATA  <= 8'h00;
    end else begin
      O_READ_VALID <= rd_vol || rd_any;
      if (rd_vol || (rd_any && I_CMD_TO_VOLATILE)) begin
        O_READ_DATA <= vol_view;
      end else if (rd_any) begin
        O_READ_DATA <= nv_r;
      end
    end
  end

  always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      O_WRITE_ENABLE_LATCH <= 1'b0;
      O_WRITE_DONE         <= 1'b0;
      O_WRITE_REFUSED      <= 1'b0;
      O_MAP_INVERT         <= 1'b0;
      O_REGION_LOCK_BITS   <= 4'h0;
      O_REGION_OP_REFUSED  <= 1'b0;
    end else begin
      O_WRITE_ENABLE_LATCH <= nv_wen_r || v_wen_r;
      O_WRITE_DONE         <= wr_ok;
      O_WRITE_REFUSED      <= wr_cmd && !wr_ok;
      O_MAP_INVERT         <= map_invert_r;
      O_REGION_LOCK_BITS   <= nv_r[LOCK_HI_BIT:LOCK_LO_BIT];
      O_REGION_OP_REFUSED  <= I_REGION_OP_VALID
                              && nv_r[LOCK_LO_BIT + 32'(I_REGION_OP_INDEX)];
    end
  end

endmodule : config1_regs

// file: config1_pkg.sv
// constants shared by the configuration register one block
package config1_pkg;

  // ****************************************************************
  // command opcodes
  // ****************************************************************
  localparam logic [7:0] WRITE_REGISTERS_CMD          = 8'h01;
  localparam logic [7:0] WRITE_ANY_REGISTER_CMD       = 8'h71;
  localparam logic [7:0] READ_ANY_REGISTER_CMD        = 8'h65;
  localparam logic [7:0] READ_CONFIG_ONE_CMD          = 8'h35;
  localparam logic [7:0] NONVOLATILE_WRITE_ENABLE_CMD = 8'h06;
  localparam logic [7:0] VOLATILE_WRITE_ENABLE_CMD    = 8'h50;

  // ****************************************************************
  // field positions of both register images
  // ****************************************************************
  localparam int SUSPEND_BIT    = 7;
  localparam int MAP_INVERT_BIT = 6;
  localparam int LOCK_HI_BIT    = 5;
  localparam int LOCK_LO_BIT    = 2;
  localparam int WIDE_IO_BIT    = 1;
  localparam int REG_LOCK_BIT   = 0;

  // ****************************************************************
  // reset values, open protection mode and minimum write-registers byte count
  // ****************************************************************
  localparam logic [7:0] CONFIG1_NV_RESET  = 8'h00;
  localparam logic [7:0] CONFIG1_VOL_RESET = 8'h00;
  localparam logic [2:0] PROT_MODE_OPEN    = 3'h7;
  localparam logic [1:0] WRR_CONFIG_BYTES  = 2'h2;

  // ****************************************************************
  // timing counts at 100 MHz
  // ****************************************************************
  localparam int CLK_PERIOD_NS    = 10;
  localparam int WIDTH_SWITCH_NS  = 10;
  localparam int WIDTH_SWITCH_CYC =
    (WIDTH_SWITCH_NS / CLK_PERIOD_NS) < 1 ? 1 : (WIDTH_SWITCH_NS / CLK_PERIOD_NS);

endpackage : config1_pkg

// file: pin_sync3.sv
// three stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module pin_sync3 #(
  parameter logic RESET_LEVEL = 1'b1
) (
  // clock and reset
  input  wire logic i_clk,
  input  wire logic i_nrst,
  // pin and filtered level
  input  wire logic i_pin,
  output logic      o_level
);

  logic s1_r;
  logic s2_r;
  logic s3_r;

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      s1_r <= RESET_LEVEL;
      s2_r <= RESET_LEVEL;
      s3_r <= RESET_LEVEL;
    end else begin
      s1_r <= i_pin;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // a change counts only once stages two and three agree
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_level <= RESET_LEVEL;
    end else if (s2_r == s3_r) begin
      o_level <= s3_r;
    end
  end

endmodule : pin_sync3

// file: config1_regs_asserts.sv
// checker for the configuration register one block ports
`timescale 1ns/1ps
module config1_regs_asserts
  import config1_pkg::*;
(
  // clock and reset
  input wire logic       I_REF_CLK,
  input wire logic       I_NRST,
  input wire logic       I_SW_RST,
  // watched inputs
  input wire logic       I_CMD_VALID,
  input wire logic [7:0] I_CMD_OP,
  input wire logic       I_BUSY,
  input wire logic       I_FOUR_WIRE_COMMAND_PROTOCOL,
  input wire logic       I_REGION_OP_VALID,
  input wire logic [1:0] I_REGION_OP_INDEX,
  // watched outputs
  input wire logic       O_READ_VALID,
  input wire logic       O_WRITE_ENABLE_LATCH,
  input wire logic       O_WRITE_DONE,
  input wire logic       O_WRITE_REFUSED,
  input wire logic [3:0] O_REGION_LOCK_BITS,
  input wire logic       O_REGION_OP_REFUSED,
  input wire logic       O_FOUR_BIT_WIDTH,
  input wire logic       O_WP_EFFECTIVE_N
);
  logic hit_r;
  default clocking cb @(posedge I_REF_CLK); endclocking
  default disable iff (!I_NRST);
  // lock state of the addressed region at the request edge
  always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
    if (!I_NRST) hit_r <= 1'b0;
    else         hit_r <= O_REGION_LOCK_BITS[I_REGION_OP_INDEX];
  end
  a_read_answer: assert property (I_CMD_VALID && I_CMD_OP == READ_CONFIG_ONE_CMD && !I_BUSY
    |=> O_READ_VALID) else $error("read answer missing");
  a_write_answer: assert property (I_CMD_VALID && I_CMD_OP == WRITE_ANY_REGISTER_CMD && !I_BUSY
    |=> O_WRITE_DONE ^ O_WRITE_REFUSED) else $error("write answer missing");
  a_busy_silent: assert property (I_CMD_VALID && I_BUSY
    |=> !O_WRITE_DONE && !O_WRITE_REFUSED) else $error("busy write answered");
  a_latch_needed: assert property (I_CMD_VALID && !I_BUSY && !O_WRITE_ENABLE_LATCH
    |=> !O_WRITE_DONE) else $error("write done without latch");
  a_done_clears: assert property (O_WRITE_DONE |=> !O_WRITE_ENABLE_LATCH)
    else $error("latch kept after write");
  a_sw_clears: assert property (I_SW_RST |-> ##2 !O_WRITE_ENABLE_LATCH)
    else $error("latch kept after soft reset");
  a_region_refuse: assert property (I_REGION_OP_VALID |=> O_REGION_OP_REFUSED == hit_r)
    else $error("region refusal wrong");
  a_locks_sticky: assert property ((O_REGION_LOCK_BITS & $past(O_REGION_LOCK_BITS))
    == $past(O_REGION_LOCK_BITS)) else $error("region lock cleared");
  a_protocol_width: assert property ($rose(I_FOUR_WIRE_COMMAND_PROTOCOL)
    |-> ##[1:3] O_FOUR_BIT_WIDTH) else $error("width not forced");
  a_wp_quad: assert property (O_FOUR_BIT_WIDTH && $past(O_FOUR_BIT_WIDTH, 2)
    |-> O_WP_EFFECTIVE_N) else $error("protect pin seen in four bit width");
endmodule : config1_regs_asserts
bind config1_regs config1_regs_asserts config1_regs_asserts_inst (.*);

// file: config1_host.sv
// host model issuing decoded register commands
`timescale 1ns/1ps
module config1_host
  import config1_pkg::*;
(
  // clock
  input  wire logic i_clk,
  // command
  output logic       o_valid,
  output logic [7:0] o_op,
  output logic [1:0] o_bytes,
  output logic [7:0] o_data,
  output logic       o_hits,
  output logic       o_to_vol
);
  initial begin
    o_valid = 1'b0; o_op = 8'h00; o_bytes = 2'h0;
    o_data = 8'h00; o_hits = 1'b0; o_to_vol = 1'b0;
  end
  // one command per call; released op, data and hit fields are inverted, bytes and to-volatile keep their last value
  task automatic send(input logic [7:0] op, input logic [1:0] nb, input logic [7:0] d,
                      input logic hit, input logic tv);
    @(negedge i_clk);
    o_valid = 1'b1; o_op = op; o_bytes = nb; o_data = d; o_hits = hit; o_to_vol = tv;
    @(negedge i_clk);
    o_valid = 1'b0; o_op = ~op; o_data = ~d; o_hits = ~hit;
  endtask : send
  // matching enable then the write itself
  task automatic wr(input logic nv, input logic [7:0] op, input logic [7:0] d);
    send(nv ? NONVOLATILE_WRITE_ENABLE_CMD : VOLATILE_WRITE_ENABLE_CMD, 2'h0, 8'h00, 1'b0, 1'b0);
    send(op, WRR_CONFIG_BYTES, d, 1'b1, !nv);
  endtask : wr
endmodule : config1_host

// file: config1_regs_tb_top.sv
// self-checking bench for the configuration register one block
`timescale 1ns/1ps
module config1_regs_tb_top
  import config1_pkg::*;
;
  logic I_REF_CLK = 1'b0, I_NRST = 1'b0, I_SW_RST = 1'b0, I_CS_N = 1'b1, I_WP_N = 1'b1;
  logic I_LINE3 = 1'b1, I_FOUR_WIRE_COMMAND_PROTOCOL = 1'b0, I_LINE3_RESET_ENABLE = 1'b0;
  logic I_SUSPENDED = 1'b0, I_BUSY = 1'b0, I_STATUS_PROTECT_PIN_GATED = 1'b0;
  logic I_REGION_OP_VALID = 1'b0, I_CMD_VALID, I_CMD_HITS_CONFIG1, I_CMD_TO_VOLATILE;
  logic [2:0] I_PROTECTION_MODE_FIELD = 3'h0;
  logic [1:0] I_REGION_OP_INDEX = 2'h0, I_CMD_BYTES, e;
  logic [7:0] I_CMD_OP, I_CMD_DATA, O_READ_DATA, d, v;
  logic O_READ_VALID, O_WRITE_ENABLE_LATCH, O_WRITE_DONE, O_WRITE_REFUSED, O_MAP_INVERT;
  logic O_REGION_OP_REFUSED, O_FOUR_BIT_WIDTH, O_WP_EFFECTIVE_N, O_LINE3_IS_RESET, O_HW_RESET;
  logic [3:0] O_REGION_LOCK_BITS;
  logic [7:0] rq[$];
  logic [1:0] wq[$];
  int miscompares = 0, n_checks = 0, cyc = 0, k;
  always #5 I_REF_CLK = ~I_REF_CLK;
  config1_regs #(.NV_IMAGE_INIT(8'h42)) config1_regs_inst (.*);
  config1_host config1_host_inst (.i_clk(I_REF_CLK), .o_valid(I_CMD_VALID), .o_op(I_CMD_OP),
    .o_bytes(I_CMD_BYTES), .o_data(I_CMD_DATA), .o_hits(I_CMD_HITS_CONFIG1),
    .o_to_vol(I_CMD_TO_VOLATILE));
  task automatic chk(input logic [7:0] x, input logic [7:0] a);
    n_checks++;
    if (x !== a) begin
      miscompares++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, x, a);
    end
  endtask : chk
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : complete_run
  task automatic rd(input logic vol, input logic [7:0] x);
    rq.push_back(x);
    config1_host_inst.send(vol ? READ_CONFIG_ONE_CMD : READ_ANY_REGISTER_CMD, 2'h0, 8'h00, 1'b1, vol);
  endtask : rd
  task automatic wexp(input logic vol, input logic [7:0] x, input logic [1:0] r);
    wq.push_back(r);
    config1_host_inst.wr(!vol, WRITE_ANY_REGISTER_CMD, x);
  endtask : wexp
  // ****************************************************************
  // result watcher
  // ****************************************************************
  always @(negedge I_REF_CLK) begin
    if (O_READ_VALID === 1'b1) chk(rq.size() ? rq.pop_front() : ~O_READ_DATA, O_READ_DATA);
    if (O_WRITE_DONE === 1'b1 || O_WRITE_REFUSED === 1'b1) begin
      e = wq.size() ? wq.pop_front() : 2'h3;
      chk(e, {O_WRITE_DONE, O_WRITE_REFUSED});
    end
  end
  always @(posedge I_REF_CLK) begin
    cyc++;
    if (cyc == 5000) begin
      miscompares++;
      complete_run();
    end
  end
  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    d = $urandom(66);
    repeat (5) @(negedge I_REF_CLK);
    I_NRST = 1'b1;
    I_WP_N = 1'b0;
    repeat (2) @(negedge I_REF_CLK);
    rd(1'b1, 8'h42);
    repeat (6) @(negedge I_REF_CLK);
    chk({O_MAP_INVERT, O_FOUR_BIT_WIDTH, O_WP_EFFECTIVE_N}, 8'h07);
    wq.push_back(2'h1);
    config1_host_inst.send(WRITE_ANY_REGISTER_CMD, 2'h0, 8'h8C, 1'b1, 1'b0);
    wexp(1'b0, 8'h8C, 2'h2);
    rd(1'b0, 8'h0C);
    rd(1'b1, 8'h4E);
    for (k = 0; k < 4; k++) begin
      @(negedge I_REF_CLK) begin I_REGION_OP_VALID = 1'b1; I_REGION_OP_INDEX = k[1:0]; end
      @(negedge I_REF_CLK) I_REGION_OP_VALID = 1'b0;
      chk(O_REGION_OP_REFUSED, k < 2);
    end
    d = $urandom() & 8'hFE;
    wq.push_back(2'h2);
    config1_host_inst.wr(1'b0, WRITE_REGISTERS_CMD, d);
    v = {1'b0, d[6], 4'h3, d[1], 1'b0};
    rd(1'b1, v);
    chk({O_MAP_INVERT, O_FOUR_BIT_WIDTH}, {d[6], d[1]});
    I_SUSPENDED = 1'b1;
    repeat (2) @(negedge I_REF_CLK);
    rd(1'b1, v | 8'h80);
    I_SUSPENDED = 1'b0;
    I_FOUR_WIRE_COMMAND_PROTOCOL = 1'b1;
    repeat (4) @(negedge I_REF_CLK);
    chk(O_FOUR_BIT_WIDTH, 8'h01);
    I_FOUR_WIRE_COMMAND_PROTOCOL = 1'b0;
    wexp(1'b1, 8'h80, 2'h2);
    I_STATUS_PROTECT_PIN_GATED = 1'b1;
    repeat (6) @(negedge I_REF_CLK);
    wexp(1'b1, 8'h40, 2'h1);
    I_STATUS_PROTECT_PIN_GATED = 1'b0;
    chk(O_WRITE_ENABLE_LATCH, 8'h01);
    wq.push_back(2'h2);
    config1_host_inst.send(WRITE_ANY_REGISTER_CMD, 2'h0, 8'h40, 1'b1, 1'b1);
    @(negedge I_REF_CLK);
    chk(O_WRITE_ENABLE_LATCH, 8'h00);
    I_BUSY = 1'b1;
    config1_host_inst.wr(1'b0, WRITE_ANY_REGISTER_CMD, 8'h00);
    I_BUSY = 1'b0;
    wexp(1'b1, 8'h41, 2'h2);
    wexp(1'b1, 8'h40, 2'h1);
    @(negedge I_REF_CLK) I_SW_RST = 1'b1;
    @(negedge I_REF_CLK) I_SW_RST = 1'b0;
    rd(1'b1, 8'h0D);
    I_LINE3_RESET_ENABLE = 1'b1;
    repeat (2) @(negedge I_REF_CLK);
    I_LINE3 = 1'b0;
    for (k = 0; k < 20 && O_HW_RESET !== 1'b1; k++) @(negedge I_REF_CLK);
    chk(O_HW_RESET, 8'h01);
    I_LINE3 = 1'b1;
    repeat (8) @(negedge I_REF_CLK);
    rd(1'b1, 8'h0C);
    wexp(1'b0, 8'h01, 2'h2);
    rd(1'b0, 8'h0C);
    I_PROTECTION_MODE_FIELD = PROT_MODE_OPEN;
    wexp(1'b0, 8'h01, 2'h2);
    I_PROTECTION_MODE_FIELD = 3'h0;
    wexp(1'b0, 8'h40, 2'h1);
    rd(1'b0, 8'h0D);
    repeat (4) @(negedge I_REF_CLK);
    chk(rq.size() + wq.size(), 8'h00);
    complete_run();
  end
endmodule : config1_regs_tb_top
